// *** design/port_pins.sv ***
/*
  Pin logic of the open-drain address/data port and the input-only port.
  Assumes the core delivers latch writes and bus requests synchronous to clk_sys;
  pin inputs come from outside and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - open-drain port bit with latch 1 releases the pin and reads as input
// - external data access shows low address byte first, then data byte
// - while acting as bus, port drives 1 bits high actively
// - second port is 8-bit input only with no drivers
// - input port bits start analog; writing 0 makes a bit digital
// - trigger pin serves counter 2 capture/reload and up/down direction
// - address latch strobe marks low address byte on bus
module port_pins (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // core writes to port latches
  input wire logic od_wr,
  input wire logic [7:0] od_wdata,
  input wire logic in_wr,
  input wire logic [7:0] in_wdata,
  // external data access request from core
  input wire logic bus_start,
  input wire logic bus_write,
  input wire logic [7:0] bus_addr_lo,
  input wire logic [7:0] bus_wdata,
  // open-drain port pins
  input wire logic [7:0] od_pin_in,
  output logic [7:0] od_pin_out,
  output logic [7:0] od_pin_oe,
  // input-only port pins
  input wire logic [7:0] in_pin,
  // results to core
  output logic [7:0] od_read,
  output logic [7:0] in_read,
  output logic [7:0] analog_mode,
  output logic address_latch_strobe,
  output logic bus_busy,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  output logic counter2_external_trigger,
  output logic counter2_count_up
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } bus_state_e;

  // ************************************************************
  // port latches
  // ************************************************************
  logic [7:0] od_latch_r;
  logic [7:0] in_latch_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      od_latch_r <= port_pins_pkg::ODPORT_RESET;
    end else if (od_wr) begin
      od_latch_r <= od_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_latch_r <= port_pins_pkg::INPORT_RESET;
    end else if (in_wr) begin
      in_latch_r <= in_wdata;
    end
  end

  // ************************************************************
  // pin synchronisers, three stages per bit
  // ************************************************************
  logic [7:0] od_s1_r, od_s2_r, od_s3_r, od_clean_r;
  logic [7:0] in_s1_r, in_s2_r, in_s3_r, in_clean_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      od_s1_r <= 8'hFF;
      od_s2_r <= 8'hFF;
      od_s3_r <= 8'hFF;
      in_s1_r <= 8'h00;
      in_s2_r <= 8'h00;
      in_s3_r <= 8'h00;
    end else begin
      od_s1_r <= od_pin_in;
      od_s2_r <= od_s1_r;
      od_s3_r <= od_s2_r;
      in_s1_r <= in_pin;
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
    end
  end

  // a change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < port_pins_pkg::PORT_W; g++) begin : g_clean
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          od_clean_r[g] <= 1'b1;
          in_clean_r[g] <= 1'b0;
        end else begin
          if (od_s2_r[g] == od_s3_r[g]) begin
            od_clean_r[g] <= od_s3_r[g];
          end
          if (in_s2_r[g] == in_s3_r[g]) begin
            in_clean_r[g] <= in_s3_r[g];
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // external data access sequencer
  // ************************************************************
  bus_state_e state_r;
  logic [7:0] data_hold_r;
  logic write_hold_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      data_hold_r <= 8'h00;
      write_hold_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (bus_start) begin
            state_r <= ST_ADDR;
            data_hold_r <= bus_wdata;
            write_hold_r <= bus_write;
          end
        end
        ST_ADDR: begin
          state_r <= ST_DATA;
        end
        ST_DATA: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // pin drivers, registered
  // ************************************************************
  // bus reads sample sync stage two; a read cycle releases the bus so memory can drive
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      od_pin_out <= 8'h00;
      od_pin_oe <= 8'h00;
      address_latch_strobe <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      address_latch_strobe <= 1'b0;
      bus_busy <= 1'b1;
      if (state_r == ST_IDLE && bus_start) begin
        od_pin_out <= bus_addr_lo;
        od_pin_oe <= 8'hFF;
        address_latch_strobe <= 1'b1;
      end else if (state_r == ST_ADDR && write_hold_r) begin
        od_pin_out <= data_hold_r;
        od_pin_oe <= 8'hFF;
      end else if (state_r == ST_ADDR) begin
        od_pin_out <= 8'h00;
        od_pin_oe <= 8'h00;
      end else begin
        // port mode: only 0 bits are driven, 1 bits float
        od_pin_out <= 8'h00;
        od_pin_oe <= ~od_latch_r;
        bus_busy <= 1'b0;
      end
    end
  end

  // reads wait two cycles: the level of the released cycle must reach sync stage two first
  logic [1:0] rd_pipe_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_pipe_r <= 2'b00;
      bus_rdata <= 8'h00;
      bus_rvalid <= 1'b0;
    end else begin
      rd_pipe_r <= {rd_pipe_r[0], (state_r == ST_DATA) && !write_hold_r};
      bus_rvalid <= rd_pipe_r[1];
      if (rd_pipe_r[1]) begin
        bus_rdata <= od_s2_r;
      end
    end
  end

  // ************************************************************
  // read-back and input-only port
  // ************************************************************
  // analog bits read as 0 so a floating analog level never reaches logic
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      od_read <= 8'hFF;
      in_read <= 8'h00;
      analog_mode <= 8'hFF;
      counter2_external_trigger <= 1'b0;
      counter2_count_up <= 1'b0;
    end else begin
      od_read <= od_clean_r;
      in_read <= in_clean_r & ~in_latch_r;
      analog_mode <= in_latch_r;
      counter2_external_trigger <= in_clean_r[port_pins_pkg::TRIG_BIT]
                                   & ~in_latch_r[port_pins_pkg::TRIG_BIT];
      counter2_count_up <= in_clean_r[port_pins_pkg::TRIG_BIT]
                           & ~in_latch_r[port_pins_pkg::TRIG_BIT];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_od_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!bus_busy && !address_latch_strobe) |-> ((od_pin_oe & $past(od_latch_r)) == 8'h00))
    else $error("open-drain port drives a latch-1 bit");
  chk_addr_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_IDLE && bus_start) |=> (od_pin_out == $past(bus_addr_lo)))
    else $error("address byte not presented first");
  chk_strobe_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    address_latch_strobe |-> (od_pin_oe == 8'hFF && bus_busy))
    else $error("strobe without driven address");
  chk_write_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_ADDR && write_hold_r) |=> (od_pin_out == $past(data_hold_r) && od_pin_oe == 8'hFF))
    else $error("write data not driven after address");
  chk_strobe_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    address_latch_strobe |=> !address_latch_strobe)
    else $error("strobe longer than one cycle");
  chk_reset_ones: assert property (@(posedge clk_sys)
    !rst_n |=> (od_latch_r == 8'hFF && in_latch_r == 8'hFF))
    else $error("latches not all ones after reset");
  chk_analog_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((in_read & analog_mode) == 8'h00))
    else $error("analog bit reads as digital");
  chk_trig_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
    counter2_external_trigger == counter2_count_up)
    else $error("trigger and direction disagree");
  chk_in_digital: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!in_latch_r[0] && !in_wr) ##1 !in_latch_r[0] |-> in_read[0] == $past(in_clean_r[0]))
    else $error("digital input bit not passed");
  chk_read_latency: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_DATA && !write_hold_r) |-> ##3 bus_rvalid)
    else $error("read data not returned after data phase");
  chk_analog_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_wr |=> ##1 (analog_mode == $past(in_wdata, 2)))
    else $error("input port mode does not follow latch write");

endmodule

`default_nettype wire

// *** include/port_pins_pkg.sv ***
/*
  Constants for the open-drain bus port and the input-only analog/digital port.
  Assumes a single 200 MHz core clock and a synchronous active-low reset.
*/
package port_pins_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] ODPORT_RESET = 8'hFF;
  localparam logic [7:0] INPORT_RESET = 8'hFF;
  localparam int TRIG_BIT = 1;
  localparam int SYNC_DEPTH = 3;
  // bus access sequence: address phase, then data phase
  localparam int ADDR_PHASE_CYC = 1;
endpackage

// *** tb/ext_mem_model.sv ***
/*
  External data memory with its address latch, on the open-drain port.
  Assumes the device drives the bus on clk_sys and releases it for reads.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // clock
  input wire logic clk_sys,
  // device side of the bus
  input wire logic [7:0] od_pin_out,
  input wire logic [7:0] od_pin_oe,
  input wire logic address_latch_strobe,
  // level the outside world puts on released pins
  input wire logic [7:0] idle_level,
  // resolved pin level
  output logic [7:0] od_pin_in
);
  logic [7:0] mem_r [256];
  logic [7:0] addr_r;
  logic [2:0] phase_r = 3'h0;
  always_ff @(posedge clk_sys) begin
    if (address_latch_strobe) begin
      addr_r <= od_pin_out;
      phase_r <= 3'h1;
    end else if (phase_r != 3'h0) begin
      phase_r <= (phase_r == 3'h3) ? 3'h0 : phase_r + 3'h1;
    end
    if (phase_r == 3'h1 && od_pin_oe == 8'hFF) begin
      mem_r[addr_r] <= od_pin_out;
    end
  end
  // memory drives only released bits, so a bus clash shows as bad read data
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (od_pin_oe[i]) od_pin_in[i] = od_pin_out[i];
      else if (phase_r != 3'h0) od_pin_in[i] = mem_r[addr_r][i];
      else od_pin_in[i] = idle_level[i];
    end
  end
endmodule
`default_nettype wire

// *** tb/port_pins_test.sv ***
/*
  Self-checking bench for port_pins with an external memory model.
  Assumes a 200 MHz clk_sys and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module port_pins_test;
  logic clk_sys = 1'b0, rst_n = 1'b0, od_wr = 1'b0, in_wr = 1'b0;
  logic bus_start = 1'b0, bus_write = 1'b0;
  logic [7:0] od_wdata = 8'h00, in_wdata = 8'h00, bus_addr_lo = 8'h00, bus_wdata = 8'h00;
  logic [7:0] in_pin = 8'h00, idle_level = 8'h00;
  logic [7:0] od_pin_in, od_pin_out, od_pin_oe, od_read, in_read, analog_mode, bus_rdata;
  logic ale, busy, rvalid, trig, up;
  logic [7:0] v, a, p, d, ad;
  int fail_count = 0, n_compared = 0, i;
  integer seed = 32'hDE786764;
  port_pins dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .od_wr(od_wr), .od_wdata(od_wdata),
    .in_wr(in_wr), .in_wdata(in_wdata), .bus_start(bus_start), .bus_write(bus_write),
    .bus_addr_lo(bus_addr_lo), .bus_wdata(bus_wdata), .od_pin_in(od_pin_in),
    .od_pin_out(od_pin_out), .od_pin_oe(od_pin_oe), .in_pin(in_pin), .od_read(od_read),
    .in_read(in_read), .analog_mode(analog_mode), .address_latch_strobe(ale),
    .bus_busy(busy), .bus_rdata(bus_rdata), .bus_rvalid(rvalid),
    .counter2_external_trigger(trig), .counter2_count_up(up));
  ext_mem_model mem_u (.clk_sys(clk_sys), .od_pin_out(od_pin_out), .od_pin_oe(od_pin_oe),
    .address_latch_strobe(ale), .idle_level(idle_level), .od_pin_in(od_pin_in));
  // ********
  // helpers
  // ********
  function automatic logic [7:0] od_exp(input logic [7:0] lat, input logic [7:0] lvl);
    return lat & lvl;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic bus_op(input logic w, input logic [7:0] a0, input logic [7:0] d0);
    int k;
    @(posedge clk_sys);
    bus_start <= 1'b1;
    bus_write <= w;
    bus_addr_lo <= a0;
    bus_wdata <= d0;
    @(posedge clk_sys);
    bus_start <= 1'b0;
    #1;
    for (k = 0; k < 4 && ale !== 1'b1; k++) tick(1);
    `CHK("strobe", 1'b1, ale)
    `CHK("addr", a0, od_pin_out)
    `CHK("addr oe", 8'hFF, od_pin_oe)
    `CHK("busy", 1'b1, busy)
    if (w) begin
      tick(1);
      `CHK("wdata", d0, od_pin_out)
      `CHK("wdata oe", 8'hFF, od_pin_oe)
    end else begin
      for (k = 0; k < 8 && rvalid !== 1'b1; k++) tick(1);
      `CHK("rvalid", 1'b1, rvalid)
      `CHK("rdata", d0, bus_rdata)
    end
    tick(4);
    `CHK("busy end", 1'b0, busy)
  endtask
  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ********
  // sequence
  // ********
  initial forever #2.5 clk_sys = ~clk_sys;
  // cut a hang well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    `CHK("oe rst", 8'h00, od_pin_oe)
    `CHK("mode rst", 8'hFF, analog_mode)
    `CHK("in rst", 8'h00, in_read)
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      a = (i < 2) ? v : 8'($random(seed));
      p = 8'($random(seed));
      d = (i == 1) ? 8'hFF : 8'($random(seed));
      ad = 8'($random(seed));
      @(posedge clk_sys);
      od_wr <= 1'b1;
      od_wdata <= v;
      in_wr <= 1'b1;
      in_wdata <= a;
      idle_level <= p;
      in_pin <= p;
      @(posedge clk_sys);
      od_wr <= 1'b0;
      in_wr <= 1'b0;
      tick(8);
      `CHK("oe", ~v, od_pin_oe)
      `CHK("od read", od_exp(v, p), od_read)
      `CHK("mode", a, analog_mode)
      `CHK("in read", od_exp(~a, p), in_read)
      `CHK("trigger", ~a[1] & p[1], trig)
      `CHK("count up", ~a[1] & p[1], up)
      bus_op(1'b1, ad, d);
      `CHK("oe back", ~v, od_pin_oe)
      bus_op(1'b0, ad, d);
    end
    // reset in mid-run, then a read as the first request after it
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    `CHK("oe mid rst", 8'h00, od_pin_oe)
    `CHK("od read mid rst", 8'hFF, od_read)
    `CHK("mode mid rst", 8'hFF, analog_mode)
    `CHK("in mid rst", 8'h00, in_read)
    `CHK("trig mid rst", 1'b0, trig)
    bus_op(1'b0, ad, d);
    report_and_stop;
  end
endmodule
`default_nettype wire
